// [include/ets_pkg.sv]
// constants and types for the exception and trap sequencer
//
// Overview of operation
// - software trap saves return pc and status into the exception save pair
// - software trap writes its code into the low 16 bits of the cause register
// - software trap sets the in-trap and mask-all status bits
// - trap vector 0..0f goes to 0x40, vector 10..1f goes to 0x50
// - return with in-trap set reloads pc and status from the exception pair
// - in-trap flag lives at status bit 6, set by software trap, illegal opcode and debug break
// - opcode 10..5 all ones, 26..23 from 7 to f, bit 16 zero is illegal
// - illegal opcode saves into debug pair, sets nmi, trap, mask bits, goes 0x60
// - debug break saves into debug pair, sets three flags, enters debug mode, 0x60
// - debug break is taken whatever the mask or status flags say
// - debug return reloads pc and status from the debug pair
// - higher priority request preempts service, lower priority stays pending
// - maskable nesting only while mask-all is clear
// - each request has a 3-bit priority, 0 highest and 7 lowest
// - after reset every request is masked at priority 7
// - pending or suspended service resumes only after a return instruction
// - no maskable acknowledge while the nmi handler runs
// - no acknowledge between a non-sampling instruction and the next one
// - enable, mask, psw load, protect store or irq register access block sampling
// - return from maskable service clears the top in-service bit, not otherwise
// - mask-all flag lives at status bit 5 and blocks maskable requests
package ets_pkg;

  // ==========================================================================
  // status word layout
  localparam int PSW_W = 32;
  localparam int PSW_MASK_ALL_BIT = 5;
  localparam int PSW_IN_TRAP_BIT = 6;
  localparam int PSW_NMI_SVC_BIT = 7;
  localparam logic [31:0] PSW_RESET = 32'h0000_0020;

  // ==========================================================================
  // handler addresses and cause codes
  localparam logic [31:0] VEC_TRAP_LO = 32'h0000_0040;
  localparam logic [31:0] VEC_TRAP_HI = 32'h0000_0050;
  localparam logic [31:0] VEC_DEBUG = 32'h0000_0060;
  localparam logic [31:0] VEC_NMI = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0080;
  localparam int VEC_IRQ_SHIFT = 4;
  localparam int CAUSE_W = 16;
  localparam logic [15:0] CAUSE_TRAP_BASE = 16'h0040;
  localparam logic [15:0] CAUSE_ILLEGAL = 16'h0060;
  localparam logic [15:0] CAUSE_NMI = 16'h0010;
  localparam logic [15:0] CAUSE_IRQ_BASE = 16'h0080;

  // ==========================================================================
  // illegal opcode fields
  localparam logic [5:0] ILL_OPC = 6'h3f;
  localparam logic [3:0] ILL_SUB_MIN = 4'h7;
  localparam int ILL_OPC_LSB = 5;
  localparam int ILL_SUB_LSB = 23;
  localparam int ILL_ZERO_BIT = 16;

  // ==========================================================================
  // maskable requests
  localparam int IRQ_NUM = 8;
  localparam int IRQ_IDX_W = 3;
  localparam int PRIO_W = 3;
  localparam int LEVELS = 8;
  localparam logic [2:0] PRIO_RESET = 3'h7;
  localparam logic MASK_RESET = 1'b1;
  localparam int CTRL_MASK_BIT = 6;

  // ==========================================================================
  // system register numbers for the load instruction
  localparam logic [4:0] SR_EXC_PC = 5'h00;
  localparam logic [4:0] SR_EXC_STATUS = 5'h01;
  localparam logic [4:0] SR_CAUSE = 5'h04;
  localparam logic [4:0] SR_PSW = 5'h05;
  localparam logic [4:0] SR_DBG_PC = 5'h10;
  localparam logic [4:0] SR_DBG_STATUS = 5'h11;

  // ==========================================================================
  // sequencer action taken in one cycle
  typedef enum logic [2:0] {
    ACT_NONE  = 3'b000,
    ACT_DBT   = 3'b001,
    ACT_ILL   = 3'b010,
    ACT_TRAP  = 3'b011,
    ACT_RETURN_FROM_EXCEPTION_INSTR  = 3'b100,
    ACT_DEBUG_RETURN_INSTR = 3'b101,
    ACT_NMI   = 3'b110,
    ACT_IRQ   = 3'b111
  } ets_act_t;

endpackage : ets_pkg

// [src/ets_prio_pick.sv]
// picks the unmasked pending request with the best priority level
module ets_prio_pick
  import ets_pkg::*;
(
  input wire logic [ets_pkg::IRQ_NUM-1:0] req,
  input wire logic [ets_pkg::IRQ_NUM-1:0] mask,
  input wire logic [ets_pkg::IRQ_NUM*ets_pkg::PRIO_W-1:0] prio,
  output logic found,
  output logic [ets_pkg::IRQ_IDX_W-1:0] idx,
  output logic [ets_pkg::PRIO_W-1:0] level
);

  // ==========================================================================
  // linear search; ties go to the lowest request number
  always_comb begin
    found = 1'b0;
    idx = '0;
    level = PRIO_RESET;
    for (int i = 0; i < IRQ_NUM; i++) begin
      if (req[i] && !mask[i] && (!found || prio[i*PRIO_W +: PRIO_W] < level)) begin
        found = 1'b1;
        idx = IRQ_IDX_W'(i);
        level = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end

endmodule // ets_prio_pick

// [src/ets_trap_seq.sv]
// exception, trap and nested interrupt sequencer of the cpu core
module ets_trap_seq
  import ets_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] ret_pc,
  input wire logic sw_exc_instr,
  input wire logic [4:0] sw_exc_vector,
  input wire logic return_from_exception_instr,
  input wire logic debug_break_instr,
  input wire logic debug_return_instr,
  input wire logic enable_irq_instr,
  input wire logic mask_irq_instr,
  input wire logic load_sys_reg_instr,
  input wire logic [4:0] sys_reg_num,
  input wire logic [31:0] sys_reg_wdata,
  input wire logic guarded_reg_access,
  input wire logic irq_ctrl_wr,
  input wire logic [ets_pkg::IRQ_IDX_W-1:0] irq_ctrl_idx,
  input wire logic [7:0] irq_ctrl_wdata,
  input wire logic [ets_pkg::IRQ_NUM-1:0] irq_req,
  input wire logic nmi_req,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [ets_pkg::PSW_W-1:0] program_status_word,
  output logic [31:0] exc_saved_pc,
  output logic [31:0] exc_saved_status,
  output logic [31:0] exception_cause_reg,
  output logic [31:0] debug_saved_pc,
  output logic [31:0] debug_saved_status,
  output logic [ets_pkg::LEVELS-1:0] in_service_prio_reg,
  output logic [ets_pkg::IRQ_NUM-1:0] irq_mask_bits,
  output logic debug_mode,
  output logic irq_ack,
  output logic [ets_pkg::IRQ_IDX_W-1:0] irq_ack_id,
  output logic nmi_ack
);
  import ets_pkg::*;

  // ==========================================================================
  // helpers

  // opcode pattern that the decoder must refuse
  function automatic logic is_illegal(input logic [31:0] w);
    logic [3:0] sub;
    sub = w[ILL_SUB_LSB +: 4];
    return (w[ILL_OPC_LSB +: 6] == ILL_OPC) && (sub >= ILL_SUB_MIN) && !w[ILL_ZERO_BIT];
  endfunction

  // best in-service level: lowest set bit
  function automatic logic [3:0] top_level(input logic [LEVELS-1:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state
  logic [PSW_W-1:0] psw_q;
  logic [31:0] exc_pc_q;
  logic [31:0] exc_st_q;
  logic [31:0] dbg_pc_q;
  logic [31:0] dbg_st_q;
  logic [31:0] nmi_pc_q;
  logic [31:0] nmi_st_q;
  logic [CAUSE_W-1:0] cause_q;
  logic [LEVELS-1:0] in_service_prio_reg_q;
  logic [IRQ_NUM-1:0] mask_q;
  logic [IRQ_NUM*PRIO_W-1:0] prio_q;
  logic dbg_mode_q;
  logic block_q;
  logic redir_q;
  logic [31:0] redir_pc_q;
  logic ack_q;
  logic [IRQ_IDX_W-1:0] ack_id_q;
  logic nmi_ack_q;

  // ==========================================================================
  // decode of the cycle's action
  logic mask_all;
  logic in_trap;
  logic nmi_svc;
  logic nonsample_now;
  logic pick_found;
  logic [IRQ_IDX_W-1:0] pick_idx;
  logic [PRIO_W-1:0] pick_level;
  logic [3:0] cur_level;
  logic can_ack;
  logic psw_load;
  ets_act_t act;

  assign mask_all = psw_q[PSW_MASK_ALL_BIT];
  assign in_trap = psw_q[PSW_IN_TRAP_BIT];
  assign nmi_svc = psw_q[PSW_NMI_SVC_BIT];
  assign psw_load = load_sys_reg_instr && (sys_reg_num == SR_PSW);
  assign cur_level = top_level(in_service_prio_reg_q);

  // instructions after which the request sampler is closed for one instruction
  assign nonsample_now = enable_irq_instr || mask_irq_instr || psw_load || guarded_reg_access || irq_ctrl_wr;

  ets_prio_pick u_pick (
    .req(irq_req),
    .mask(mask_q),
    .prio(prio_q),
    .found(pick_found),
    .idx(pick_idx),
    .level(pick_level)
  );

  // acknowledge only a strictly better level than the one in service
  assign can_ack = pick_found && ({1'b0, pick_level} < cur_level)
                   && !mask_all
                   && !nmi_svc
                   && !block_q && !nonsample_now;

  // one action per cycle; the debug break ignores every flag
  always_comb begin
    if (debug_break_instr) begin
      act = ACT_DBT;
    end else if (instr_valid && is_illegal(instr_word)) begin
      act = ACT_ILL;
    end else if (sw_exc_instr) begin
      act = ACT_TRAP;
    end else if (return_from_exception_instr) begin
      act = ACT_RETURN_FROM_EXCEPTION_INSTR;
    end else if (debug_return_instr) begin
      act = ACT_DEBUG_RETURN_INSTR;
    end else if (nmi_req && !nmi_svc && !block_q && !nonsample_now) begin
      act = ACT_NMI;
    end else if (can_ack && !instr_valid) begin
      act = ACT_IRQ;
    end else begin
      act = ACT_NONE;
    end
  end

  // ==========================================================================
  // sampling window: stays shut until the instruction after a closing one
  always_ff @(posedge clock) begin
    if (reset) begin
      block_q <= 1'b0;
    end else if (nonsample_now) begin
      block_q <= 1'b1;
    end else if (instr_valid) begin
      block_q <= 1'b0;
    end
  end

  // ==========================================================================
  // status word
  always_ff @(posedge clock) begin
    if (reset) begin
      psw_q <= PSW_RESET;
    end else begin
      unique case (act)
        ACT_TRAP, ACT_IRQ: begin
          psw_q[PSW_MASK_ALL_BIT] <= 1'b1;
          if (act == ACT_TRAP) begin
            psw_q[PSW_IN_TRAP_BIT] <= 1'b1;
          end
        end
        ACT_DBT, ACT_ILL: begin
          psw_q[PSW_NMI_SVC_BIT] <= 1'b1;
          psw_q[PSW_IN_TRAP_BIT] <= 1'b1;
          psw_q[PSW_MASK_ALL_BIT] <= 1'b1;
        end
        ACT_NMI: begin
          psw_q[PSW_NMI_SVC_BIT] <= 1'b1;
          psw_q[PSW_MASK_ALL_BIT] <= 1'b1;
        end
        ACT_RETURN_FROM_EXCEPTION_INSTR: begin
          // in-trap picks the exception pair first, then the nmi pair
          if (in_trap || !nmi_svc) begin
            psw_q <= exc_st_q;
          end else begin
            psw_q <= nmi_st_q;
          end
        end
        ACT_DEBUG_RETURN_INSTR: psw_q <= dbg_st_q;
        ACT_NONE: begin
          if (psw_load) begin
            psw_q <= sys_reg_wdata;
          end else if (enable_irq_instr) begin
            psw_q[PSW_MASK_ALL_BIT] <= 1'b0;
          end else if (mask_irq_instr) begin
            psw_q[PSW_MASK_ALL_BIT] <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // exception save pair and cause; software may reload them for nesting
  always_ff @(posedge clock) begin
    if (reset) begin
      exc_pc_q <= '0;
      exc_st_q <= '0;
      cause_q <= '0;
    end else if (act == ACT_TRAP || act == ACT_IRQ) begin
      exc_pc_q <= ret_pc;
      exc_st_q <= psw_q;
      if (act == ACT_TRAP) begin
        cause_q <= CAUSE_TRAP_BASE + {11'h000, sw_exc_vector};
      end else begin
        cause_q <= CAUSE_IRQ_BASE + {13'h0000, pick_idx};
      end
    end else if (act == ACT_ILL) begin
      cause_q <= CAUSE_ILLEGAL;
    end else if (act == ACT_NMI) begin
      cause_q <= CAUSE_NMI;
    end else if (act == ACT_NONE && load_sys_reg_instr) begin
      // software save and restore around nested service
      if (sys_reg_num == SR_EXC_PC) begin
        exc_pc_q <= sys_reg_wdata;
      end
      if (sys_reg_num == SR_EXC_STATUS) begin
        exc_st_q <= sys_reg_wdata;
      end
      if (sys_reg_num == SR_CAUSE) begin
        cause_q <= sys_reg_wdata[CAUSE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // debug save pair and debug mode
  always_ff @(posedge clock) begin
    if (reset) begin
      dbg_pc_q <= '0;
      dbg_st_q <= '0;
      dbg_mode_q <= 1'b0;
    end else if (act == ACT_DBT || act == ACT_ILL) begin
      dbg_pc_q <= ret_pc;
      dbg_st_q <= psw_q;
      if (act == ACT_DBT) begin
        dbg_mode_q <= 1'b1;
      end
    end else if (act == ACT_DEBUG_RETURN_INSTR) begin
      dbg_mode_q <= 1'b0;
    end else if (act == ACT_NONE && load_sys_reg_instr) begin
      if (sys_reg_num == SR_DBG_PC) begin
        dbg_pc_q <= sys_reg_wdata;
      end
      if (sys_reg_num == SR_DBG_STATUS) begin
        dbg_st_q <= sys_reg_wdata;
      end
    end
  end

  // ==========================================================================
  // nmi save pair, not visible to software
  always_ff @(posedge clock) begin
    if (reset) begin
      nmi_pc_q <= '0;
      nmi_st_q <= '0;
    end else if (act == ACT_NMI) begin
      nmi_pc_q <= ret_pc;
      nmi_st_q <= psw_q;
    end
  end

  // ==========================================================================
  // per-request control: priority and mask, written by software
  generate
    for (genvar g = 0; g < IRQ_NUM; g++) begin : g_ctrl
      always_ff @(posedge clock) begin
        if (reset) begin
          mask_q[g] <= MASK_RESET;
          prio_q[g*PRIO_W +: PRIO_W] <= PRIO_RESET;
        end else if (irq_ctrl_wr && irq_ctrl_idx == IRQ_IDX_W'(g)) begin
          mask_q[g] <= irq_ctrl_wdata[CTRL_MASK_BIT];
          prio_q[g*PRIO_W +: PRIO_W] <= irq_ctrl_wdata[PRIO_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // in-service levels; a return only clears one for maskable service
  always_ff @(posedge clock) begin
    if (reset) begin
      in_service_prio_reg_q <= '0;
    end else if (act == ACT_IRQ) begin
      in_service_prio_reg_q[pick_level] <= 1'b1;
    end else if (act == ACT_RETURN_FROM_EXCEPTION_INSTR && !in_trap && !nmi_svc && !cur_level[3]) begin
      in_service_prio_reg_q[cur_level[2:0]] <= 1'b0;
    end
  end

  // ==========================================================================
  // redirect to the handler or the restored address
  always_ff @(posedge clock) begin
    if (reset) begin
      redir_q <= 1'b0;
      redir_pc_q <= '0;
    end else begin
      redir_q <= (act != ACT_NONE);
      unique case (act)
        ACT_TRAP: redir_pc_q <= sw_exc_vector[4] ? VEC_TRAP_HI : VEC_TRAP_LO;
        ACT_DBT, ACT_ILL: redir_pc_q <= VEC_DEBUG;
        ACT_NMI: redir_pc_q <= VEC_NMI;
        ACT_IRQ: redir_pc_q <= VEC_IRQ_BASE + ({29'h0, pick_idx} << VEC_IRQ_SHIFT);
        ACT_RETURN_FROM_EXCEPTION_INSTR: redir_pc_q <= (in_trap || !nmi_svc) ? exc_pc_q : nmi_pc_q;
        ACT_DEBUG_RETURN_INSTR: redir_pc_q <= dbg_pc_q;
        ACT_NONE: redir_pc_q <= redir_pc_q;
      endcase
    end
  end

  // ==========================================================================
  // acknowledge pulses tell the request logic to drop its flag
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= 1'b0;
      ack_id_q <= '0;
      nmi_ack_q <= 1'b0;
    end else begin
      ack_q <= (act == ACT_IRQ);
      nmi_ack_q <= (act == ACT_NMI);
      if (act == ACT_IRQ) begin
        ack_id_q <= pick_idx;
      end
    end
  end

  // ==========================================================================
  // outputs
  assign redirect_valid = redir_q;
  assign redirect_pc = redir_pc_q;
  assign program_status_word = psw_q;
  assign exc_saved_pc = exc_pc_q;
  assign exc_saved_status = exc_st_q;
  assign exception_cause_reg = {16'h0000, cause_q};
  assign debug_saved_pc = dbg_pc_q;
  assign debug_saved_status = dbg_st_q;
  assign in_service_prio_reg = in_service_prio_reg_q;
  assign irq_mask_bits = mask_q;
  assign debug_mode = dbg_mode_q;
  assign irq_ack = ack_q;
  assign irq_ack_id = ack_id_q;
  assign nmi_ack = nmi_ack_q;

endmodule // ets_trap_seq

// [testbench/ets_trap_seq_props.sv]
// port-level checker for the exception and trap sequencer
module ets_trap_seq_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] ret_pc,
  input wire logic sw_exc_instr,
  input wire logic [4:0] sw_exc_vector,
  input wire logic return_from_exception_instr,
  input wire logic debug_break_instr,
  input wire logic debug_return_instr,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic [ets_pkg::PSW_W-1:0] program_status_word,
  input wire logic [31:0] exc_saved_pc,
  input wire logic [31:0] exc_saved_status,
  input wire logic [31:0] exception_cause_reg,
  input wire logic [31:0] debug_saved_pc,
  input wire logic [31:0] debug_saved_status,
  input wire logic [ets_pkg::LEVELS-1:0] in_service_prio_reg,
  input wire logic [ets_pkg::IRQ_NUM-1:0] irq_mask_bits,
  input wire logic debug_mode,
  input wire logic irq_ack
);
  import ets_pkg::*;
  // ==========================================================================
  // decoded events, in the sequencer's precedence so lower ones are not blamed
  logic illegal;
  logic trap_go;
  logic ret_go;
  logic debug_return_instr_go;
  assign illegal = instr_valid && instr_word[10:5] == 6'h3f && instr_word[26:23] >= 4'h7 && !instr_word[16];
  assign trap_go = sw_exc_instr && !debug_break_instr && !illegal;
  assign ret_go = return_from_exception_instr && !debug_break_instr && !illegal && !sw_exc_instr;
  assign debug_return_instr_go = debug_return_instr && !debug_break_instr && !illegal && !sw_exc_instr && !return_from_exception_instr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ==========================================================================
  // assertions
  a_trap_vector: assert property (trap_go |=> redirect_valid &&
    redirect_pc == (($past(sw_exc_vector) > 5'h0f) ? 32'h50 : 32'h40)) else $error("trap vector address wrong");
  a_trap_save: assert property (trap_go |=> exc_saved_pc == $past(ret_pc) &&
    exc_saved_status == $past(program_status_word)) else $error("trap save pair wrong");
  a_trap_cause: assert property (trap_go |=> exception_cause_reg == 32'h40 + $past(sw_exc_vector))
    else $error("trap cause code wrong");
  a_trap_flags: assert property (trap_go |=> program_status_word[6:5] == 2'b11)
    else $error("trap status flags not set");
  a_return_from_exception_instr_restore: assert property (ret_go && program_status_word[6] |=> redirect_valid &&
    redirect_pc == $past(exc_saved_pc) && program_status_word == $past(exc_saved_status)) else $error("return restore wrong");
  a_debug_break: assert property (debug_break_instr |=> redirect_pc == 32'h60 && debug_mode &&
    program_status_word[7:5] == 3'h7 && debug_saved_pc == $past(ret_pc)) else $error("debug break entry wrong");
  a_illegal_trap: assert property (illegal && !debug_break_instr |=> redirect_pc == 32'h60 &&
    program_status_word[7:5] == 3'h7 && debug_saved_status == $past(program_status_word)) else $error("bad opcode entry wrong");
  a_debug_return: assert property (debug_return_instr_go |=> redirect_pc == $past(debug_saved_pc) && !debug_mode &&
    program_status_word == $past(debug_saved_status)) else $error("debug return restore wrong");
  a_ack_gating: assert property (irq_ack |-> ($past(program_status_word) & 32'h0000_00a0) == 32'h0 &&
    !$past(instr_valid)) else $error("acknowledge while blocked");
  a_reset_defaults: assert property ($fell(reset) |-> irq_mask_bits == 8'hff &&
    program_status_word == PSW_RESET && in_service_prio_reg == 8'h00) else $error("reset defaults wrong");
endmodule // ets_trap_seq_props

// [testbench/tb_ets_trap_seq.sv]
// self-checking bench for the exception and trap sequencer
module tb_ets_trap_seq;
  timeunit 1ns;
  timeprecision 1ns;
  import ets_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [9:0] ev = 10'h0;
  logic nmi_req = 1'b0;
  logic [4:0] sys_reg_num = 5'h05;
  logic [31:0] instr_word = 32'h0, ret_pc = 32'h0, sys_reg_wdata = 32'h0;
  logic [4:0] sw_exc_vector = 5'h0;
  logic [2:0] irq_ctrl_idx = 3'h0;
  logic [7:0] irq_ctrl_wdata = 8'h0, irq_req = 8'h0;
  logic irq_ctrl_wr, load_sys_reg_instr, guarded_reg_access, instr_valid, mask_irq_instr, enable_irq_instr;
  logic debug_return_instr, debug_break_instr, return_from_exception_instr, sw_exc_instr;
  logic redirect_valid, debug_mode, irq_ack, nmi_ack;
  logic [31:0] redirect_pc, program_status_word, exc_saved_pc, exc_saved_status, exception_cause_reg;
  logic [31:0] debug_saved_pc, debug_saved_status, ps;
  logic [7:0] in_service_prio_reg, irq_mask_bits;
  logic [2:0] irq_ack_id;
  logic [4:0] vt [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
  logic [3:0] st [4] = '{4'h7, 4'hf, 4'h6, 4'h7};
  int mismatches = 0;
  int cmp_count = 0;

  // event pulses share one vector so a single write starts or ends them
  assign {irq_ctrl_wr, load_sys_reg_instr, guarded_reg_access, instr_valid, mask_irq_instr, enable_irq_instr,
    debug_return_instr, debug_break_instr, return_from_exception_instr, sw_exc_instr} = ev;

  ets_trap_seq uut (.*);

  // 25 MHz core clock
  initial forever #20 clock = ~clock;

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one event cycle; outputs are looked at one edge later, once settled
  task automatic op(input logic [9:0] k, input logic [31:0] pc, input logic [31:0] word);
    @(posedge clock);
    ev <= k;
    ret_pc <= pc;
    instr_word <= word;
    sw_exc_vector <= word[4:0];
    sys_reg_wdata <= word;
    irq_ctrl_idx <= word[10:8];
    irq_ctrl_wdata <= word[7:0];
    @(posedge clock);
    ev <= 10'h0;
    #1;
  endtask

  // software write of a system register; the number falls back to the status word after
  task automatic sreg(input logic [4:0] n, input logic [31:0] d);
    @(posedge clock);
    ev <= 10'h100;
    sys_reg_num <= n;
    sys_reg_wdata <= d;
    @(posedge clock);
    ev <= 10'h0;
    sys_reg_num <= SR_PSW;
    #1;
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk(irq_ack, 1'b0);
    end
  endtask

  // bounded wait for an acknowledge, then its identity
  task automatic wait_ack(input logic [2:0] id);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (irq_ack !== 1'b1 && i < 10);
    chk(irq_ack, 1'b1);
    chk(irq_ack_id, id);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // cuts a hang short; the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    $display("CHECK FAILED at %0t: timeout", $time);
    final_report;
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk(irq_mask_bits, 8'hff);
    chk(program_status_word, PSW_RESET);
    // vector boundaries of the software trap, each followed by its return
    foreach (vt[j]) begin
      ps = program_status_word;
      op(10'h001, 32'h1000 + vt[j], {27'h0, vt[j]});
      chk(redirect_pc, vt[j][4] ? 32'h50 : 32'h40);
      chk(exc_saved_pc, 32'h1000 + vt[j]);
      chk(exc_saved_status, ps);
      chk(exception_cause_reg, 32'h40 + vt[j]);
      chk(program_status_word[6:5], 2'b11);
      op(10'h002, 32'h0, 32'h0);
      chk(redirect_pc, 32'h1000 + vt[j]);
      chk(program_status_word, ps);
    end
    // debug break taken although mask-all is set
    ps = program_status_word;
    op(10'h004, 32'h2000, 32'h0);
    chk(redirect_pc, 32'h60);
    chk(program_status_word[7:5], 3'h7);
    chk(debug_saved_pc, 32'h2000);
    chk(debug_saved_status, ps);
    chk(debug_mode, 1'b1);
    op(10'h008, 32'h0, 32'h0);
    chk(redirect_pc, 32'h2000);
    chk(program_status_word, ps);
    chk(debug_mode, 1'b0);
    // bad opcode at both ends of the sub-opcode range and two near misses
    for (int j = 0; j < 4; j++) begin
      op(10'h040, 32'h3000 + j, {5'h0, st[j], 6'h0, j == 3, 5'h0, 6'h3f, 5'h0});
      chk(redirect_valid, j < 2);
      if (j < 2) begin
        chk(redirect_pc, 32'h60);
        chk(debug_saved_pc, 32'h3000 + j);
        chk(program_status_word[7:5], 3'h7);
        op(10'h008, 32'h0, 32'h0);
      end
    end
    // priorities: request 3 at level 2, 5 at level 1, 1 at level 4
    op(10'h200, 32'h0, {21'h0, 3'h3, 8'h02});
    op(10'h200, 32'h0, {21'h0, 3'h5, 8'h01});
    op(10'h200, 32'h0, {21'h0, 3'h1, 8'h04});
    chk(irq_mask_bits, 8'hd5);
    @(posedge clock) irq_req <= 8'h08;
    quiet(3);
    op(10'h020, 32'h0, 32'h0);
    op(10'h010, 32'h0, 32'h0);
    quiet(3);
    op(10'h040, 32'h0, 32'h0);
    wait_ack(3'h3);
    chk(in_service_prio_reg, 8'h04);
    @(posedge clock) irq_req <= 8'h22;
    op(10'h100, 32'h0, 32'h0);
    op(10'h080, 32'h0, 32'h0);
    quiet(2);
    op(10'h040, 32'h0, 32'h0);
    wait_ack(3'h5);
    chk(in_service_prio_reg, 8'h06);
    @(posedge clock) irq_req <= 8'h02;
    op(10'h002, 32'h0, 32'h0);
    chk(in_service_prio_reg, 8'h04);
    quiet(3);
    // handler puts back the outer pair before its own return
    sreg(SR_EXC_PC, 32'h0000_1234);
    sreg(SR_EXC_STATUS, 32'h0000_0001);
    chk(exc_saved_pc, 32'h0000_1234);
    chk(exc_saved_status, 32'h0000_0001);
    op(10'h002, 32'h0, 32'h0);
    chk(in_service_prio_reg, 8'h00);
    chk(redirect_pc, 32'h0000_1234);
    chk(program_status_word, 32'h0000_0001);
    wait_ack(3'h1);
    chk(in_service_prio_reg, 8'h10);
    // nmi service shuts out maskable requests and its return keeps the in-service level
    @(posedge clock);
    irq_req <= 8'h20;
    nmi_req <= 1'b1;
    @(posedge clock);
    nmi_req <= 1'b0;
    #1;
    chk(nmi_ack, 1'b1);
    chk(program_status_word[7:5], 3'h5);
    op(10'h010, 32'h0, 32'h0);
    op(10'h040, 32'h0, 32'h0);
    quiet(3);
    op(10'h002, 32'h0, 32'h0);
    chk(in_service_prio_reg, 8'h10);
    chk(program_status_word, 32'h0000_0021);
    @(posedge clock) irq_req <= 8'h00;
    final_report;
  end
endmodule // tb_ets_trap_seq

bind ets_trap_seq ets_trap_seq_props chk (.*);
